// ### inc/tsync_regs.svh
`ifndef TSYNC_REGS_SVH
`define TSYNC_REGS_SVH

// register indices; byte address is four times the index
`define IDX_TX_CONTROL_3 10'h183
`define IDX_TX_IO_CONFIGURATION 10'h184
`define IDX_TX_SYNCHRONIZER_CONTROL 10'h18E
`define IDX_TX_LATCHED_STATUS_3 10'h192
`define IDX_TX_INTERRUPT_MASK_3 10'h1A2
`define IDX_TX_PATH_CONFIG 10'h1F0
`define IDX_TX_REALTIME_STATUS 10'h1F1

// field positions
`define TX_CONTROL_3_FORMAT_BIT 2
`define TX_IO_CONFIGURATION_MF_PULSE_BIT 0
`define TX_IO_CONFIGURATION_DIRECTION_BIT 1
`define TX_SYNCHRONIZER_CONTROL_CRITERION_BIT 0
`define TX_SYNCHRONIZER_CONTROL_FORCE_BIT 1
`define PATH_ELASTIC_BIT 0
`define PATH_IBO_BIT 1
`define TX_LATCHED_STATUS_3_LOSS_BIT 0
`define RTS_LIVE_BIT 0
`define RTS_SYNC_PIN_BIT 1

// reset values
`define RESET_BYTE 8'h00

// framing counts
`define FRAME_BITS 8'hC1
`define D4_FRAMES 5'h0C
`define ESF_FRAMES 5'h18
`define D4_LOCK_MATCHES 5'h0C
`define ESF_LOCK_MATCHES 5'h06

`endif

// ### inc/tsync_pkg.sv
package tsync_pkg;
  typedef enum logic [1:0] {SYNC_OFF, SYNC_HUNT, SYNC_LOCKED} sync_state_t;
endpackage

// ### logic/fbit_expect.sv
`timescale 1ns/1ns
// expected framing bit for a frame slot of the multiframe
module fbit_expect (
  // format and position
  input wire logic esf,
  input wire logic [4:0] frame_idx,
  // expectation
  output logic checked,
  output logic expect_bit
);
  // d4 alternates terminal and signalling framing bits, 12 frames
  localparam logic [11:0] D4_PATTERN = 12'h03B1;
  // esf framing bits sit in every fourth frame only
  localparam logic [5:0] ESF_PATTERN = 6'h34;

  // crc bits and data-link bits are never looked at
  always_comb begin
    checked = 1'b0;
    expect_bit = 1'b0;
    if (esf) begin
      if (frame_idx[1:0] == 2'h3) begin
        checked = 1'b1;
        expect_bit = ESF_PATTERN[frame_idx[4:2]];
      end
    end else if (frame_idx < 5'h0C) begin
      checked = 1'b1;
      expect_bit = D4_PATTERN[frame_idx[3:0]];
    end
  end
endmodule

// ### logic/tx_frame_sync.sv
`timescale 1ns/1ns
`include "tsync_regs.svh"
module tx_frame_sync #(
  parameter logic [7:0] FRAME_BITS = `FRAME_BITS
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // backplane serial input pins
  input wire logic tx_serial_in,
  input wire logic tx_bit_clk,
  // transmit sync pin
  input wire logic tx_sync_pin_i,
  output logic tx_sync_pin_o,
  output logic tx_sync_pin_oe,
  // status
  output logic loss_of_frame_live,
  output logic irq_out_n
);
  import tsync_pkg::*;

  sync_state_t state_reg;
  logic [7:0] tx_control_3_reg, tx_io_configuration_reg, tx_synchronizer_control_reg, path_reg, tx_interrupt_mask_3_reg;
  logic lat_reg;
  logic bclk_s1, bclk_s2, bclk_s3, sd_s1, sd_s2, spin_s1, spin_s2;
  logic [7:0] pos_reg, slip_cnt_reg;
  logic [4:0] fidx_reg, match_cnt_reg, err_hist_reg;
  logic [4:0] mf_len, lock_need, fidx_next, err_hist_next;
  logic bit_tick, f_slot, checked, expect_bit, mismatch, esf;
  logic off_cond, err_loss, lock_hit, loss_evt, force_wr;
  logic acc, wr_commit, rd_commit, hit;
  logic [9:0] idx;
  logic [7:0] rd_byte;
  logic [2:0] errs;

  // pins come from another clock; two flops before anything reads them
  always_ff @(posedge clk) begin
    if (srst) begin
      bclk_s1 <= 1'b0;
      bclk_s2 <= 1'b0;
      bclk_s3 <= 1'b0;
      sd_s1 <= 1'b0;
      sd_s2 <= 1'b0;
      spin_s1 <= 1'b0;
      spin_s2 <= 1'b0;
    end else begin
      bclk_s1 <= tx_bit_clk;
      bclk_s2 <= bclk_s1;
      bclk_s3 <= bclk_s2;
      sd_s1 <= tx_serial_in;
      sd_s2 <= sd_s1;
      spin_s1 <= tx_sync_pin_i;
      spin_s2 <= spin_s1;
    end
  end

  // rising bit clock edge; data sampled in the same synced stage
  assign bit_tick = bclk_s2 & ~bclk_s3;
  assign esf = tx_control_3_reg[`TX_CONTROL_3_FORMAT_BIT];
  assign mf_len = esf ? `ESF_FRAMES : `D4_FRAMES;
  assign lock_need = esf ? `ESF_LOCK_MATCHES : `D4_LOCK_MATCHES;
  assign fidx_next = (fidx_reg == mf_len - 5'h01) ? 5'h00 :
                     5'(fidx_reg + 5'h01);
  assign off_cond = path_reg[`PATH_ELASTIC_BIT] |
                    path_reg[`PATH_IBO_BIT];

  // only framing-bit slots are compared; crc and data-link bits ignored
  fbit_expect u_expect (
    .esf(esf),
    .frame_idx(fidx_reg),
    .checked(checked),
    .expect_bit(expect_bit)
  );

  assign f_slot = bit_tick && pos_reg == 8'h00 && checked;
  assign mismatch = sd_s2 ^ expect_bit;

  // loss judged on the history including the current framing bit
  assign err_hist_next = {err_hist_reg[3:0], mismatch};
  always_comb begin
    errs = 3'h0;
    for (int i = 0; i < 5; i++) begin
      if (i < 4 || tx_synchronizer_control_reg[`TX_SYNCHRONIZER_CONTROL_CRITERION_BIT]) begin
        errs = 3'(errs + {2'h0, err_hist_next[i]});
      end
    end
  end
  // criterion 0: two errors in four bits, 1: two in five
  assign err_loss = f_slot && errs >= 3'h2;
  assign lock_hit = f_slot && !mismatch &&
                    match_cnt_reg == lock_need - 5'h01;

  // apb decode; one wait state so every output is a flop
  assign acc = psel & penable;
  assign wr_commit = acc & pready & pwrite;
  assign rd_commit = acc & pready & ~pwrite;
  assign idx = paddr[11:2];
  assign force_wr = wr_commit && hit &&
                    idx == `IDX_TX_SYNCHRONIZER_CONTROL &&
                    pwdata[`TX_SYNCHRONIZER_CONTROL_FORCE_BIT];
  assign loss_evt = state_reg == SYNC_LOCKED && !off_cond &&
                    (err_loss || force_wr);

  // read mux; unmapped or misaligned addresses answer with an error
  always_comb begin
    hit = paddr[1:0] == 2'h0;
    rd_byte = 8'h00;
    unique case (idx)
      `IDX_TX_CONTROL_3: rd_byte = tx_control_3_reg;
      `IDX_TX_IO_CONFIGURATION: rd_byte = tx_io_configuration_reg;
      `IDX_TX_SYNCHRONIZER_CONTROL: rd_byte = tx_synchronizer_control_reg;
      `IDX_TX_LATCHED_STATUS_3: rd_byte = {7'h00, lat_reg};
      `IDX_TX_INTERRUPT_MASK_3: rd_byte = tx_interrupt_mask_3_reg;
      `IDX_TX_PATH_CONFIG: rd_byte = path_reg;
      `IDX_TX_REALTIME_STATUS: rd_byte = {6'h00, spin_s2, loss_of_frame_live};
      default: hit = 1'b0;
    endcase
  end

  // bus handshake and read data
  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      if (acc & ~pready) begin
        prdata <= (hit && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
    end
  end

  // writable registers; force bit is a strobe and never stored
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_control_3_reg <= `RESET_BYTE;
      tx_io_configuration_reg <= `RESET_BYTE;
      tx_synchronizer_control_reg <= `RESET_BYTE;
      path_reg <= `RESET_BYTE;
      tx_interrupt_mask_3_reg <= `RESET_BYTE;
    end else if (wr_commit && hit) begin
      unique case (idx)
        `IDX_TX_CONTROL_3: tx_control_3_reg <= pwdata[7:0];
        `IDX_TX_IO_CONFIGURATION: tx_io_configuration_reg <= pwdata[7:0];
        `IDX_TX_SYNCHRONIZER_CONTROL: begin
          tx_synchronizer_control_reg <= pwdata[7:0] & ~(8'h01 << `TX_SYNCHRONIZER_CONTROL_FORCE_BIT);
        end
        `IDX_TX_INTERRUPT_MASK_3: tx_interrupt_mask_3_reg <= pwdata[7:0];
        `IDX_TX_PATH_CONFIG: path_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // latched loss flag; clears only what the read returned, set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      lat_reg <= 1'b0;
    end else if (loss_evt) begin
      lat_reg <= 1'b1;
    end else if (rd_commit && hit && idx == `IDX_TX_LATCHED_STATUS_3 &&
                 prdata[`TX_LATCHED_STATUS_3_LOSS_BIT]) begin
      lat_reg <= 1'b0;
    end
  end

  // alignment state
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= SYNC_OFF;
    end else begin
      unique case (state_reg)
        SYNC_OFF: if (!off_cond) state_reg <= SYNC_HUNT;
        SYNC_HUNT: begin
          if (off_cond) state_reg <= SYNC_OFF;
          // a force write in the lock cycle restarts the count instead
          else if (lock_hit && !force_wr) state_reg <= SYNC_LOCKED;
        end
        SYNC_LOCKED: begin
          if (off_cond) state_reg <= SYNC_OFF;
          else if (loss_evt) state_reg <= SYNC_HUNT;
        end
      endcase
    end
  end

  // bit and frame position; a hunt miss holds position for a one-bit slip
  always_ff @(posedge clk) begin
    if (srst || state_reg == SYNC_OFF) begin
      pos_reg <= 8'h00;
      fidx_reg <= 5'h00;
      slip_cnt_reg <= 8'h00;
    end else if (bit_tick) begin
      if (state_reg == SYNC_HUNT && f_slot && mismatch) begin
        // after a full frame of slips try the next frame phase
        if (slip_cnt_reg == FRAME_BITS - 8'h01) begin
          slip_cnt_reg <= 8'h00;
          fidx_reg <= fidx_next;
        end else begin
          slip_cnt_reg <= 8'(slip_cnt_reg + 8'h01);
        end
      end else if (pos_reg == FRAME_BITS - 8'h01) begin
        pos_reg <= 8'h00;
        fidx_reg <= fidx_next;
      end else begin
        pos_reg <= 8'(pos_reg + 8'h01);
      end
    end
  end

  // match count during hunt, error history once locked
  always_ff @(posedge clk) begin
    if (srst || state_reg == SYNC_OFF || force_wr) begin
      match_cnt_reg <= 5'h00;
      err_hist_reg <= 5'h00;
    end else if (f_slot) begin
      if (state_reg == SYNC_HUNT) begin
        err_hist_reg <= 5'h00;
        match_cnt_reg <= mismatch ? 5'h00 : 5'(match_cnt_reg + 5'h01);
      end else begin
        match_cnt_reg <= 5'h00;
        err_hist_reg <= loss_evt ? 5'h00 : err_hist_next;
      end
    end
  end

  // live flag and interrupt, both registered
  always_ff @(posedge clk) begin
    if (srst) begin
      loss_of_frame_live <= 1'b0;
      irq_out_n <= 1'b1;
    end else begin
      loss_of_frame_live <= state_reg == SYNC_HUNT;
      irq_out_n <= ~(lat_reg & tx_interrupt_mask_3_reg[`TX_LATCHED_STATUS_3_LOSS_BIT]);
    end
  end

  // sync pin: pulse lasts one bit period; drives only when host asks
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_sync_pin_o <= 1'b0;
      tx_sync_pin_oe <= 1'b0;
    end else begin
      tx_sync_pin_oe <= tx_io_configuration_reg[`TX_IO_CONFIGURATION_DIRECTION_BIT];
      if (state_reg != SYNC_LOCKED) begin
        tx_sync_pin_o <= 1'b0;
      end else if (bit_tick) begin
        tx_sync_pin_o <= pos_reg == 8'h00 &&
                         (!tx_io_configuration_reg[`TX_IO_CONFIGURATION_MF_PULSE_BIT] ||
                          fidx_reg == 5'h00);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence loss_seq;
    state_reg == SYNC_LOCKED ##1 state_reg == SYNC_HUNT;
  endsequence
  sequence lock_seq;
    state_reg == SYNC_HUNT ##1 state_reg == SYNC_LOCKED;
  endsequence

  loss_latches_a: assert property (loss_seq |-> lat_reg)
    else $error("loss of sync did not set latched flag");
  lock_count_a: assert property (lock_seq |->
    $past(match_cnt_reg) == lock_need - 5'h01)
    else $error("lock declared without a full multiframe of matches");
  live_hunt_a: assert property (state_reg == SYNC_HUNT |=>
    loss_of_frame_live ##1 (loss_of_frame_live ||
    $past(state_reg) != SYNC_HUNT))
    else $error("live flag low while hunting");
  irq_on_a: assert property (lat_reg && tx_interrupt_mask_3_reg[0] |=> !irq_out_n)
    else $error("unmasked latched flag gave no interrupt");
  irq_off_a: assert property (!tx_interrupt_mask_3_reg[0] ##1 !tx_interrupt_mask_3_reg[0] |-> irq_out_n)
    else $error("masked flag drove interrupt");
  sticky_flag_a: assert property (lat_reg && !rd_commit |=> lat_reg)
    else $error("latched flag dropped without a read");
  no_new_a: assert property (!lat_reg && !loss_evt |=> !lat_reg)
    else $error("latched flag set without loss");
  off_idle_a: assert property (off_cond |=> state_reg == SYNC_OFF)
    else $error("synchronizer active with elastic store");
  force_hunt_a: assert property (force_wr && !off_cond &&
    state_reg != SYNC_OFF |=> state_reg == SYNC_HUNT)
    else $error("forced resync did not hunt");
  pulse_lock_a: assert property ($rose(tx_sync_pin_o) |->
    $past(state_reg) == SYNC_LOCKED)
    else $error("sync pulse while not aligned");
  mf_pulse_a: assert property ($rose(tx_sync_pin_o) &&
    $past(tx_io_configuration_reg[0]) |-> $past(fidx_reg) == 5'h00)
    else $error("multiframe pulse off the multiframe boundary");
  apb_wait_a: assert property (acc && !pready |=> pready ##1 !pready)
    else $error("apb answer not after one wait state");
endmodule

// ### tb/frame_source.sv
`timescale 1ns/1ns
// backplane source: six clk per bit, framing bit in slot 0
module frame_source #(
  parameter int FB = 8
) (
  // clock
  input wire logic clk,
  // format, 1 = esf
  input wire logic esf,
  // serial pins
  output logic ser,
  output logic bclk
);
  localparam logic [11:0] D4P = 12'h08DC;
  localparam logic [5:0] FPS = 6'h0B;
  logic [31:0] lfsr_reg = 32'h0000_6172;
  int ph = 0;
  int bi = 0;
  int frm = 0;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial begin
    ser = 1'b0;
    bclk = 1'b0;
  end
  // data moves at the bit clock fall so it is settled at the rise
  always @(posedge clk) begin
    ph <= (ph + 1) % 6;
    if (ph == 2)
      bclk <= 1'b1;
    if (ph == 5) begin
      bclk <= 1'b0;
      lfsr_reg <= lfsr(lfsr_reg);
      // one assignment per bit: framing slot or random payload
      if (bi == 0 && !esf)
        ser <= D4P[11 - frm % 12];
      else if (bi == 0 && esf && frm % 4 == 3)
        ser <= FPS[5 - frm / 4];
      else
        ser <= lfsr_reg[0];
      bi <= (bi + 1) % FB;
      if (bi == FB - 1)
        frm <= (frm + 1) % 24;
    end
  end
endmodule

// ### tb/test_t1_transmit_frame_synchronizer.sv
`timescale 1ns/1ns
`include "tsync_regs.svh"
`define CHK(a, b) check(a, b)
module test_t1_transmit_frame_synchronizer;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, ser, bclk, pin_o, pin_oe, live, irq_out_n;
  logic esf = 1'b0;
  logic pin_i;
  int error_cnt = 0;
  int n_checks = 0;
  int mdl[int];
  int lat = 0;
  int p;
  always #50 clk = ~clk;
  // undriven pin assumed pulled low on the board
  assign pin_i = pin_oe ? pin_o : 1'b0;
  tx_frame_sync #(.FRAME_BITS(8'h08)) DUT (.clk(clk), .srst(srst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_serial_in(ser), .tx_bit_clk(bclk),
    .tx_sync_pin_i(pin_i), .tx_sync_pin_o(pin_o),
    .tx_sync_pin_oe(pin_oe), .loss_of_frame_live(live),
    .irq_out_n(irq_out_n));
  frame_source #(.FB(8)) src (.clk(clk), .esf(esf), .ser(ser),
    .bclk(bclk));
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic [9:0] idx, input logic wr,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    paddr <= {idx, 2'b00};
    pwrite <= wr;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20)
      error_cnt++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input int d);
    logic [31:0] q;
    logic e;
    apb(idx, 1'b1, 32'(d), q, e);
    if (mdl.exists(idx))
      mdl[idx] = d;
    // force strobe reads back as zero
    if (idx == `IDX_TX_SYNCHRONIZER_CONTROL)
      mdl[idx] = d & ~2;
  endtask
  task automatic rd(input logic [9:0] idx);
    logic [31:0] q;
    logic e;
    logic st;
    st = (idx == `IDX_TX_LATCHED_STATUS_3);
    apb(idx, 1'b0, 32'h0000_0000, q, e);
    `CHK(q, st ? lat : (mdl.exists(idx) ? mdl[idx] : 0));
    `CHK(e, !mdl.exists(idx) && !st);
    if (st)
      lat = 0;
  endtask
  task automatic wait_live(input logic v, input int lim);
    int n;
    n = 0;
    while (live !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  // rising edges over a whole number of frames
  task automatic pulses(input int frames, output int c);
    logic last;
    last = pin_o;
    c = 0;
    repeat (frames * 48) begin
      @(posedge clk);
      if (pin_o === 1'b1 && last !== 1'b1)
        c++;
      last = pin_o;
    end
  endtask
  task automatic force_loss();
    wr(`IDX_TX_SYNCHRONIZER_CONTROL, 2);
    lat = 1;
    wait_live(1'b1, 20);
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    mdl[`IDX_TX_CONTROL_3] = 0;
    mdl[`IDX_TX_IO_CONFIGURATION] = 0;
    mdl[`IDX_TX_SYNCHRONIZER_CONTROL] = 0;
    mdl[`IDX_TX_INTERRUPT_MASK_3] = 0;
    mdl[`IDX_TX_PATH_CONFIG] = 0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    // reset values, then an unmapped place
    foreach (mdl[i])
      rd(10'(i));
    rd(`IDX_TX_LATCHED_STATUS_3);
    rd(10'h000);
    wr(`IDX_TX_INTERRUPT_MASK_3, 1);
    wr(`IDX_TX_IO_CONFIGURATION, 2);
    wait_live(1'b0, 30000);
    `CHK(live, 1'b0);
    `CHK(pin_oe, 1'b1);
    pulses(12, p);
    `CHK(p, 12);
    wr(`IDX_TX_IO_CONFIGURATION, 3);
    pulses(24, p);
    `CHK(p, 2);
    wr(`IDX_TX_IO_CONFIGURATION, 2);
    force_loss();
    `CHK(live, 1'b1);
    `CHK(irq_out_n, 1'b0);
    rd(`IDX_TX_LATCHED_STATUS_3);
    rd(`IDX_TX_LATCHED_STATUS_3);
    repeat (2) @(posedge clk);
    `CHK(irq_out_n, 1'b1);
    wr(`IDX_TX_INTERRUPT_MASK_3, 0);
    wait_live(1'b0, 30000);
    force_loss();
    `CHK(irq_out_n, 1'b1);
    rd(`IDX_TX_LATCHED_STATUS_3);
    // esf search; latched state left unread after the switch
    esf <= 1'b1;
    wr(`IDX_TX_CONTROL_3, 4);
    force_loss();
    wait_live(1'b0, 40000);
    `CHK(live, 1'b0);
    pulses(24, p);
    `CHK(p, 24);
    wr(`IDX_TX_PATH_CONFIG, 1);
    repeat (10) @(posedge clk);
    `CHK(live, 1'b0);
    pulses(24, p);
    `CHK(p, 0);
    wr(`IDX_TX_PATH_CONFIG, 2);
    pulses(24, p);
    `CHK(p, 0);
    rd(`IDX_TX_PATH_CONFIG);
    // realtime status: not hunting, pin driven low while off
    mdl[`IDX_TX_REALTIME_STATUS] = 0;
    rd(`IDX_TX_REALTIME_STATUS);
    finish_test();
  end
endmodule
